/* File: rtl/rsc_pkg.sv */
// rsc_pkg: constants and types of the multi-source reset controller
package rsc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SLOW_PERIOD_NS = 25000;
  localparam int unsigned SLOW_DIV_CYC = SLOW_PERIOD_NS * 1000 / CLK_PERIOD_PS;
  localparam logic [5:0] VOLT_RELEASE_TICKS = 6'h20;
  localparam logic [2:0] CPU_CLK_DIV_RESET = 3'h3;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_PROC_MODE_A = 14'h0004;
  localparam logic [13:0] IDX_PROC_MODE_B = 14'h0005;
  localparam logic [13:0] IDX_VMON1_CTRL = 14'h0036;
  localparam logic [13:0] IDX_VMON2_CTRL = 14'h0037;
  localparam logic [13:0] IDX_TIMER_C_CTRL_B = 14'h009b;
  localparam logic [13:0] IDX_CCR0_LO = 14'h009c;
  localparam logic [13:0] IDX_CCR0_HI = 14'h009d;
  localparam logic [13:0] IDX_PORT1_DIR = 14'h00e3;
  localparam logic [13:0] IDX_PORT3_DIR = 14'h00e7;
  localparam logic [13:0] IDX_PORT4_DIR = 14'h00ea;
  localparam logic [13:0] IDX_OPTION_WORD = 14'h0fff;
  localparam logic [13:0] IDX_RESET_CAUSE = 14'h0300;
  localparam logic [13:0] IDX_CPU_CLK_CTRL = 14'h0301;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned SOFT_RESET_REQUEST_BIT = 3;
  localparam int unsigned WATCHDOG_RESET_SELECT_BIT = 2;
  localparam int unsigned COMPARE_MODE_SELECT_BIT = 3;
  localparam int unsigned VMON_ENABLE_BIT = 0;
  localparam int unsigned VMON_RESET_MODE_BIT = 6;
  localparam int unsigned CLK_SLOW_DIV8_BIT = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PROC_MODE_RESET = 8'h00;
  localparam logic [7:0] VMON1_RESET_PIN = 8'h00;
  localparam logic [7:0] VMON1_RESET_POWER = 8'h41;
  localparam logic [7:0] VMON2_RESET = 8'h00;
  localparam logic [7:0] TIMER_C_CTRL_RESET = 8'h00;
  localparam logic [15:0] CCR0_RESET_NORMAL = 16'h0000;
  localparam logic [15:0] CCR0_RESET_COMPARE = 16'hffff;
  localparam logic [7:0] PORT_DIR_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'b101;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HOLD = 3'b001,
    ST_COUNT = 3'b010,
    ST_SYNC = 3'b011,
    ST_START = 3'b100
  } rsc_state_e;
  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b000,
    CAUSE_PIN = 3'b001,
    CAUSE_POWER_ON = 3'b010,
    CAUSE_VMON1 = 3'b011,
    CAUSE_VMON2 = 3'b100,
    CAUSE_WATCHDOG = 3'b101,
    CAUSE_SOFTWARE = 3'b110
  } rsc_cause_e;
endpackage

/* File: rtl/rsc_slow_tick.sv */
// rsc_slow_tick: divider giving one-cycle slow oscillator ticks
module rsc_slow_tick #(
  parameter int unsigned DIV = 6250
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  output logic o_tick
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic tick_next;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 16'h0001;
    if (cnt_reg == 16'(DIV - 1)) begin
      cnt_next = 16'h0000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_reg <= 16'h0000;
      o_tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      o_tick <= tick_next;
    end
  end
endmodule

/* File: rtl/rsc_reset_ctrl.sv */
// rsc_reset_ctrl: reset source merger, sequencer and reset-owned registers
//
// Chosen here: the AHB-Lite slave port and the register offsets.

// Overview of operation
// - six sources each reset: pin, power-on, monitor one, monitor two, watchdog, software.
// - low reset pin holds pins, cpu and registers in reset.
// - pin rising releases reset; cpu starts from the reset vector.
// - every reset selects slow ring clock divided by eight for the cpu.
// - internal ram is never cleared; interrupted writes may corrupt it.
// - power-on reset releases 32 slow ticks after supply passes level one.
// - power-on reset leaves monitor one reset enabled.
// - monitor one low resets; recovery waits 32 slow ticks before release.
// - monitor two low resets and restarts; its unaffected registers are kept.
// - watchdog underflow resets when the watchdog select bit is one.
// - watchdog and software resets keep their unaffected bits, initialise the rest.
// - writing one to the soft request bit resets and restarts.
// - after reset all three port direction registers are cleared to inputs.
// - capture compare zero resets to ffff in output compare mode.
// - option select word is read only for software.
// - voltage control registers reset only by pin, power-on or monitor one.
module rsc_reset_ctrl import rsc_pkg::*; #(
  parameter int unsigned SLOW_DIV = SLOW_DIV_CYC,
  parameter logic [7:0] OPTION_WORD_VALUE = 8'hff // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reset_pin_n,
  input wire logic i_supply_above_lvl1,
  input wire logic i_supply_above_lvl2,
  input wire logic i_wdt_underflow,
  input wire logic i_hsel,
  input wire logic [15:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic o_core_rst,
  output logic o_cpu_fetch_vector,
  output logic o_cpu_clk_slow_div8,
  output logic [2:0] o_cpu_clk_div,
  output logic [7:0] o_port1_dir,
  output logic [7:0] o_port3_dir,
  output logic [7:0] o_port4_dir,
  output logic [15:0] o_ccr0,
  output logic o_compare_mode
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] async_in;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  assign async_in = {i_supply_above_lvl2, i_supply_above_lvl1, i_reset_pin_n};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          sync1_reg[g] <= SYNC_RESET[g];
          sync2_reg[g] <= SYNC_RESET[g];
        end else begin
          sync1_reg[g] <= async_in[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  logic slow_tick;
  rsc_slow_tick #(
    .DIV(SLOW_DIV)
  ) u_slow_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_tick(slow_tick)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rsc_state_e state_reg, state_next;
  rsc_cause_e cause_reg, cause_next;
  logic [5:0] cnt_reg, cnt_next;
  logic powered_reg, powered_next;
  logic [7:0] mode_a_reg, mode_a_next;
  logic [7:0] mode_b_reg, mode_b_next;
  logic [7:0] vmon1_reg, vmon1_next;
  logic [7:0] vmon2_reg, vmon2_next;
  logic [7:0] tcc_reg, tcc_next;
  logic [15:0] ccr0_reg, ccr0_next;
  logic [7:0] pd1_reg, pd1_next;
  logic [7:0] pd3_reg, pd3_next;
  logic [7:0] pd4_reg, pd4_next;
  logic clk_div8_reg, clk_div8_next;
  logic wr_pend_reg, wr_pend_next;
  logic [13:0] wr_idx_reg, wr_idx_next;
  logic [31:0] rdata_next;
  logic fetch_next;

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  logic src_pin, src_por, src_vm1, src_vm2, src_wdt, src_sw;
  logic full_src, part_src, any_src, enter, bus_wr;
  always_comb begin
    bus_wr = wr_pend_reg & (state_reg == ST_RUN);
    src_pin = ~sync2_reg[0];
    src_por = ~powered_reg & ~sync2_reg[1];
    src_vm1 = powered_reg & ~sync2_reg[1] & vmon1_reg[VMON_ENABLE_BIT];
    src_vm2 = ~sync2_reg[2] & vmon2_reg[VMON_ENABLE_BIT]
      & vmon2_reg[VMON_RESET_MODE_BIT];
    src_wdt = i_wdt_underflow & mode_b_reg[WATCHDOG_RESET_SELECT_BIT];
    src_sw = bus_wr & (wr_idx_reg == IDX_PROC_MODE_A)
      & i_hwdata[SOFT_RESET_REQUEST_BIT];
    full_src = src_pin | src_por | src_vm1;
    part_src = src_vm2 | src_wdt | src_sw;
    any_src = full_src | part_src;
    enter = (state_reg == ST_RUN) & any_src;
  end

  // merged reset, combinational on assertion, released from the fsm
  assign o_core_rst = (state_reg != ST_RUN) | any_src;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cause_next = cause_reg;
    cnt_next = cnt_reg;
    fetch_next = 1'b0;
    powered_next = powered_reg | sync2_reg[1];
    if (src_pin) begin
      cause_next = CAUSE_PIN;
    end else if (src_por) begin
      cause_next = CAUSE_POWER_ON;
    end else if (src_vm1) begin
      cause_next = CAUSE_VMON1;
    end else if (enter) begin
      if (src_vm2) begin
        cause_next = CAUSE_VMON2;
      end else if (src_wdt) begin
        cause_next = CAUSE_WATCHDOG;
      end else begin
        cause_next = CAUSE_SOFTWARE;
      end
    end
    case (state_reg)
      ST_RUN: begin
        if (any_src) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (full_src | src_vm2) begin
          state_next = ST_HOLD;
        end else if (cause_reg == CAUSE_POWER_ON || cause_reg == CAUSE_VMON1) begin
          state_next = ST_COUNT;
          cnt_next = 6'h00;
        end else begin
          state_next = ST_SYNC;
        end
      end
      ST_COUNT: begin
        if (full_src | src_vm2) begin
          state_next = ST_HOLD;
        end else if (slow_tick) begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == VOLT_RELEASE_TICKS - 6'h01) begin
            state_next = ST_START;
          end
        end
      end
      ST_SYNC: begin
        if (full_src | src_vm2) begin
          state_next = ST_HOLD;
        end else if (slow_tick) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        fetch_next = 1'b1;
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // reset-owned registers and bus writes
  // ram is outside this block and is never touched here
  // ----------------------------------------------------------------
  always_comb begin
    mode_a_next = mode_a_reg;
    mode_b_next = mode_b_reg;
    vmon1_next = vmon1_reg;
    vmon2_next = vmon2_reg;
    tcc_next = tcc_reg;
    ccr0_next = ccr0_reg;
    pd1_next = pd1_reg;
    pd3_next = pd3_reg;
    pd4_next = pd4_reg;
    clk_div8_next = clk_div8_reg;
    if (enter) begin
      // initialise all but the voltage group
      mode_a_next = PROC_MODE_RESET;
      mode_b_next = PROC_MODE_RESET;
      tcc_next = TIMER_C_CTRL_RESET;
      ccr0_next = tcc_reg[COMPARE_MODE_SELECT_BIT] ?
        CCR0_RESET_COMPARE : CCR0_RESET_NORMAL;
      pd1_next = PORT_DIR_RESET;
      pd3_next = PORT_DIR_RESET;
      pd4_next = PORT_DIR_RESET;
      clk_div8_next = 1'b1;
    end
    if (full_src) begin
      // voltage group only on pin, power-on or monitor one
      vmon1_next = src_pin ? VMON1_RESET_PIN : VMON1_RESET_POWER;
      vmon2_next = VMON2_RESET;
    end else if (bus_wr & ~any_src) begin
      case (wr_idx_reg)
        IDX_PROC_MODE_A: mode_a_next = i_hwdata[7:0];
        IDX_PROC_MODE_B: mode_b_next = i_hwdata[7:0];
        IDX_VMON1_CTRL: vmon1_next = i_hwdata[7:0];
        IDX_VMON2_CTRL: vmon2_next = i_hwdata[7:0];
        IDX_TIMER_C_CTRL_B: tcc_next = i_hwdata[7:0];
        IDX_CCR0_LO: ccr0_next[7:0] = i_hwdata[7:0];
        IDX_CCR0_HI: ccr0_next[15:8] = i_hwdata[7:0];
        IDX_PORT1_DIR: pd1_next = i_hwdata[7:0];
        IDX_PORT3_DIR: pd3_next = i_hwdata[7:0];
        IDX_PORT4_DIR: pd4_next = i_hwdata[7:0];
        IDX_CPU_CLK_CTRL: clk_div8_next = i_hwdata[CLK_SLOW_DIV8_BIT];
        default: begin
          // option word, reset cause and unmapped: writes dropped
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave: zero wait, okay only, read built from next values
  // ----------------------------------------------------------------
  logic addr_ok;
  logic [13:0] a_idx;
  always_comb begin
    addr_ok = i_hsel & i_htrans[1] & i_hready;
    a_idx = i_haddr[15:2];
    wr_pend_next = addr_ok & i_hwrite;
    wr_idx_next = addr_ok ? a_idx : wr_idx_reg;
    rdata_next = o_hrdata;
    if (addr_ok & ~i_hwrite) begin
      rdata_next = 32'h0000_0000;
      case (a_idx)
        IDX_PROC_MODE_A: rdata_next[7:0] = mode_a_next;
        IDX_PROC_MODE_B: rdata_next[7:0] = mode_b_next;
        IDX_VMON1_CTRL: rdata_next[7:0] = vmon1_next;
        IDX_VMON2_CTRL: rdata_next[7:0] = vmon2_next;
        IDX_TIMER_C_CTRL_B: rdata_next[7:0] = tcc_next;
        IDX_CCR0_LO: rdata_next[7:0] = ccr0_next[7:0];
        IDX_CCR0_HI: rdata_next[7:0] = ccr0_next[15:8];
        IDX_PORT1_DIR: rdata_next[7:0] = pd1_next;
        IDX_PORT3_DIR: rdata_next[7:0] = pd3_next;
        IDX_PORT4_DIR: rdata_next[7:0] = pd4_next;
        IDX_OPTION_WORD: rdata_next[7:0] = OPTION_WORD_VALUE;
        IDX_RESET_CAUSE: rdata_next[2:0] = cause_next;
        IDX_CPU_CLK_CTRL: rdata_next[CLK_SLOW_DIV8_BIT] = clk_div8_next;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_reg <= ST_HOLD;
      cause_reg <= CAUSE_POWER_ON;
      cnt_reg <= 6'h00;
      powered_reg <= 1'b0;
      mode_a_reg <= PROC_MODE_RESET;
      mode_b_reg <= PROC_MODE_RESET;
      vmon1_reg <= VMON1_RESET_POWER;
      vmon2_reg <= VMON2_RESET;
      tcc_reg <= TIMER_C_CTRL_RESET;
      ccr0_reg <= CCR0_RESET_NORMAL;
      pd1_reg <= PORT_DIR_RESET;
      pd3_reg <= PORT_DIR_RESET;
      pd4_reg <= PORT_DIR_RESET;
      clk_div8_reg <= 1'b1;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 14'h0000;
      o_hrdata <= 32'h0000_0000;
      o_cpu_fetch_vector <= 1'b0;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      cnt_reg <= cnt_next;
      powered_reg <= powered_next;
      mode_a_reg <= mode_a_next;
      mode_b_reg <= mode_b_next;
      vmon1_reg <= vmon1_next;
      vmon2_reg <= vmon2_next;
      tcc_reg <= tcc_next;
      ccr0_reg <= ccr0_next;
      pd1_reg <= pd1_next;
      pd3_reg <= pd3_next;
      pd4_reg <= pd4_next;
      clk_div8_reg <= clk_div8_next;
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      o_hrdata <= rdata_next;
      o_cpu_fetch_vector <= fetch_next;
    end
  end

  assign o_cpu_clk_slow_div8 = clk_div8_reg;
  assign o_cpu_clk_div = CPU_CLK_DIV_RESET;
  assign o_port1_dir = pd1_reg;
  assign o_port3_dir = pd3_reg;
  assign o_port4_dir = pd4_reg;
  assign o_ccr0 = ccr0_reg;
  assign o_compare_mode = tcc_reg[COMPARE_MODE_SELECT_BIT];
endmodule

/* File: tb/rsc_supervisor_model.sv */
// rsc_supervisor_model: external reset circuit and supply monitor stand-in
module rsc_supervisor_model #(
  parameter int unsigned HOLD = 20,
  parameter int unsigned SETTLE = 16
) (
  input wire logic i_clk,
  input wire logic i_pin_req,
  input wire logic i_power_cycle,
  input wire logic i_dip1,
  input wire logic i_dip2,
  output logic o_reset_pin_n,
  output logic o_supply_above_lvl1,
  output logic o_supply_above_lvl2
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned hold_cnt = 0;
  // -----------------------------------------------------------
  // supply levels and pin hold
  // -----------------------------------------------------------
  assign o_supply_above_lvl1 = !(i_dip1 || i_power_cycle);
  assign o_supply_above_lvl2 = !(i_dip2 || i_power_cycle);
  always @(posedge i_clk) begin
    if (i_power_cycle) begin
      hold_cnt <= SETTLE + HOLD;
    end else if (i_pin_req) begin
      hold_cnt <= HOLD;
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
  // pulled up once released
  assign o_reset_pin_n = (hold_cnt == 0) && !i_pin_req && !i_power_cycle;
endmodule

/* File: tb/rsc_reset_ctrl_checker.sv */
// rsc_reset_ctrl_checker: port-level assertions of the reset controller
module rsc_reset_ctrl_checker import rsc_pkg::*; #(
  parameter int unsigned SLOW_DIV = 6250,
  parameter logic [7:0] OPTION_WORD_VALUE = 8'hff
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_reset_pin_n,
  input wire logic i_supply_above_lvl1,
  input wire logic i_hsel,
  input wire logic [15:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_core_rst,
  input wire logic o_cpu_fetch_vector,
  input wire logic o_cpu_clk_slow_div8,
  input wire logic [2:0] o_cpu_clk_div,
  input wire logic [7:0] o_port1_dir,
  input wire logic [7:0] o_port3_dir,
  input wire logic [7:0] o_port4_dir,
  input wire logic [15:0] o_ccr0,
  input wire logic o_compare_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PIN_MAX = SLOW_DIV + 10;
  localparam int unsigned VOLT_MIN = 31 * SLOW_DIV;
  localparam int unsigned VOLT_MAX = 32 * SLOW_DIV + 10;
  logic cm_reg;
  logic arm_reg;
  logic pact_reg;
  int unsigned vcnt_reg;
  int unsigned pcnt_reg;
  // -----------------------------------------------------------
  // helper counters
  // -----------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cm_reg <= 1'b0;
      arm_reg <= 1'b1;
      pact_reg <= 1'b0;
      vcnt_reg <= 0;
      pcnt_reg <= 0;
    end else begin
      if (!o_core_rst) cm_reg <= o_compare_mode;
      if (!i_reset_pin_n || !o_core_rst) arm_reg <= 1'b0;
      else if (!i_supply_above_lvl1) arm_reg <= 1'b1;
      if (!i_supply_above_lvl1 || !o_core_rst) vcnt_reg <= 0;
      else vcnt_reg <= vcnt_reg + 1;
      if (!i_reset_pin_n) pact_reg <= 1'b1;
      else if (o_cpu_fetch_vector) pact_reg <= 1'b0;
      if (!i_reset_pin_n || o_cpu_fetch_vector) pcnt_reg <= 0;
      else if (pact_reg) pcnt_reg <= pcnt_reg + 1;
    end
  end
  // -----------------------------------------------------------
  // properties
  // -----------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_pin_hold;
    !i_reset_pin_n [*3] |-> o_core_rst && !o_cpu_fetch_vector;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("low pin not holding reset");
  property p_fetch_pulse;
    o_cpu_fetch_vector |=> !o_cpu_fetch_vector;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch pulse too long");
  property p_pin_release;
    pcnt_reg <= PIN_MAX;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("slow restart after pin");
  property p_clk_slow;
    $fell(o_core_rst) |-> o_cpu_clk_slow_div8 && o_cpu_clk_div == CPU_CLK_DIV_RESET;
  endproperty
  a_clk_slow: assert property (p_clk_slow) else $error("cpu clock not slow div8");
  property p_dirs;
    $fell(o_core_rst) |-> (o_port1_dir | o_port3_dir | o_port4_dir) == 8'h00;
  endproperty
  a_dirs: assert property (p_dirs) else $error("port direction not input");
  property p_ccr0;
    $fell(o_core_rst) |-> o_ccr0 == (cm_reg ? 16'hffff : 16'h0000) && !o_compare_mode;
  endproperty
  a_ccr0: assert property (p_ccr0) else $error("compare zero reset value wrong");
  property p_volt;
    $fell(o_core_rst) && arm_reg |-> vcnt_reg >= VOLT_MIN && vcnt_reg <= VOLT_MAX;
  endproperty
  a_volt: assert property (p_volt) else $error("voltage release count wrong");
  property p_opt;
    i_hsel && i_htrans[1] && i_hready && !i_hwrite && i_haddr == {IDX_OPTION_WORD, 2'b00}
      |=> o_hrdata == {24'h000000, OPTION_WORD_VALUE};
  endproperty
  a_opt: assert property (p_opt) else $error("option word changed");
  c_volt: cover property ($fell(o_core_rst) && arm_reg);
  c_cm: cover property ($fell(o_core_rst) && cm_reg);
  c_pin: cover property ($rose(i_reset_pin_n));
endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_checker #(
  .SLOW_DIV(SLOW_DIV),
  .OPTION_WORD_VALUE(OPTION_WORD_VALUE)
) i_rsc_reset_ctrl_checker (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reset_pin_n(i_reset_pin_n),
  .i_supply_above_lvl1(i_supply_above_lvl1), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
  .o_core_rst(o_core_rst), .o_cpu_fetch_vector(o_cpu_fetch_vector),
  .o_cpu_clk_slow_div8(o_cpu_clk_slow_div8), .o_cpu_clk_div(o_cpu_clk_div),
  .o_port1_dir(o_port1_dir), .o_port3_dir(o_port3_dir), .o_port4_dir(o_port4_dir),
  .o_ccr0(o_ccr0), .o_compare_mode(o_compare_mode)
);

/* File: tb/rsc_reset_ctrl_tb.sv */
// rsc_reset_ctrl_tb: self-checking bench of the reset controller
module rsc_reset_ctrl_tb import rsc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned D = 8;
  localparam int unsigned HOLD = 20 * D;
  localparam logic [7:0] OPT = 8'h5a; // arbitrary value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wdt = 1'b0;
  logic pin_req = 1'b0;
  logic pcyc = 1'b0;
  logic dip1 = 1'b0;
  logic dip2 = 1'b0;
  logic hsel = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic pin_n, lvl1, lvl2, hreadyout, hresp, core_rst, fetch, slow8, cmode;
  logic [31:0] hrdata;
  logic [31:0] rdata;
  int unsigned n;
  int fails = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  rsc_supervisor_model #(.HOLD(HOLD), .SETTLE(16 * D)) i_rsc_supervisor_model (
    .i_clk(clk), .i_pin_req(pin_req), .i_power_cycle(pcyc), .i_dip1(dip1), .i_dip2(dip2),
    .o_reset_pin_n(pin_n), .o_supply_above_lvl1(lvl1), .o_supply_above_lvl2(lvl2)
  );
  rsc_reset_ctrl #(.SLOW_DIV(D), .OPTION_WORD_VALUE(OPT)) i_rsc_reset_ctrl (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_reset_pin_n(pin_n), .i_supply_above_lvl1(lvl1),
    .i_supply_above_lvl2(lvl2), .i_wdt_underflow(wdt), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
    .o_core_rst(core_rst), .o_cpu_fetch_vector(fetch), .o_cpu_clk_slow_div8(slow8),
    .o_cpu_clk_div(), .o_port1_dir(), .o_port3_dir(), .o_port4_dir(), .o_ccr0(),
    .o_compare_mode(cmode)
  );
  // -----------------------------------------------------------
  // tasks
  // -----------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [13:0] idx, input logic w, input logic [7:0] wd,
                      output logic [31:0] rd);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= {idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    @(posedge clk);
    while (hreadyout !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    rd = hrdata;
  endtask
  task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    xfer(idx, 1'b1, v, rdata);
  endtask
  task automatic rdc(input logic [13:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00, rdata);
    check(rdata, {24'h000000, exp});
  endtask
  task automatic wait_fetch(output int unsigned cyc);
    cyc = 0;
    while (fetch !== 1'b1 && cyc < 40 * D + HOLD) begin
      @(posedge clk);
      cyc++;
    end
    check({31'h0, fetch}, 32'h1);
    @(posedge clk);
    check({31'h0, core_rst}, 32'h0);
  endtask
  task automatic pulse_wdt;
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
  endtask
  // -----------------------------------------------------------
  // sequence
  // -----------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    wait_fetch(n);
    check({31'h0, n >= 31 * D}, 32'h1);
    rdc(IDX_VMON1_CTRL, VMON1_RESET_POWER);
    rdc(IDX_RESET_CAUSE, {5'h00, CAUSE_POWER_ON});
    xfer(IDX_CPU_CLK_CTRL, 1'b0, 8'h00, rdata);
    check(rdata & 32'h1, 32'h1);
    wr(IDX_OPTION_WORD, 8'h00);
    rdc(IDX_OPTION_WORD, OPT);
    rdc(14'h0400, 8'h00);
    wr(IDX_PORT1_DIR, 8'hff);
    wr(IDX_PORT3_DIR, 8'hff);
    wr(IDX_PORT4_DIR, 8'hff);
    wr(IDX_TIMER_C_CTRL_B, 8'h08);
    rdc(IDX_PORT3_DIR, 8'hff);
    wr(IDX_CPU_CLK_CTRL, 8'h00);
    check({31'h0, cmode}, 32'h1);
    rdc(IDX_CPU_CLK_CTRL, 8'h00);
    wr(IDX_PROC_MODE_A, 8'h08);
    wait_fetch(n);
    rdc(IDX_RESET_CAUSE, {5'h00, CAUSE_SOFTWARE});
    rdc(IDX_PORT1_DIR, 8'h00);
    rdc(IDX_PORT3_DIR, 8'h00);
    rdc(IDX_PORT4_DIR, 8'h00);
    rdc(IDX_CCR0_LO, 8'hff);
    rdc(IDX_CCR0_HI, 8'hff);
    rdc(IDX_TIMER_C_CTRL_B, 8'h00);
    rdc(IDX_PROC_MODE_A, 8'h00);
    rdc(IDX_CPU_CLK_CTRL, 8'h01);
    check({31'h0, slow8}, 32'h1);
    rdc(IDX_VMON1_CTRL, VMON1_RESET_POWER);
    pulse_wdt();
    repeat (3) @(posedge clk);
    check({31'h0, core_rst}, 32'h0);
    wr(IDX_PROC_MODE_B, 8'h04);
    pulse_wdt();
    wait_fetch(n);
    rdc(IDX_RESET_CAUSE, {5'h00, CAUSE_WATCHDOG});
    rdc(IDX_PROC_MODE_B, 8'h00);
    rdc(IDX_CCR0_HI, 8'h00);
    wr(IDX_VMON2_CTRL, 8'h41);
    dip2 <= 1'b1;
    repeat (10) @(posedge clk);
    check({31'h0, core_rst}, 32'h1);
    dip2 <= 1'b0;
    wait_fetch(n);
    rdc(IDX_RESET_CAUSE, {5'h00, CAUSE_VMON2});
    rdc(IDX_VMON2_CTRL, 8'h41);
    dip1 <= 1'b1;
    repeat (10) @(posedge clk);
    dip1 <= 1'b0;
    wait_fetch(n);
    check({31'h0, n >= 31 * D}, 32'h1);
    rdc(IDX_RESET_CAUSE, {5'h00, CAUSE_VMON1});
    rdc(IDX_VMON1_CTRL, VMON1_RESET_POWER);
    pin_req <= 1'b1;
    @(posedge clk);
    pin_req <= 1'b0;
    repeat (8) @(posedge clk);
    wr(IDX_PORT4_DIR, 8'h3c);
    wait_fetch(n);
    rdc(IDX_PORT4_DIR, 8'h00);
    rdc(IDX_RESET_CAUSE, {5'h00, CAUSE_PIN});
    rdc(IDX_VMON1_CTRL, VMON1_RESET_PIN);
    sys_rst <= 1'b1;
    pcyc <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    pcyc <= 1'b0;
    wait_fetch(n);
    rdc(IDX_PORT1_DIR, 8'h00);
    summarize();
  end
  initial begin
    #100us;
    fails++;
    summarize();
  end
endmodule
